// >>> pp_ports.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
// What this block does
// - Timer port: eight bidirectional pins, data+direction.
// - Direction 1 drives pin, 0 leaves input.
// - Direction registers reset to zero.
// - Data registers not reset.
// - Data registers readable and writable anytime, except high-address and data-bus ones in bus modes.
// - Alternate function: writes stored, pin unchanged.
// - Timer port bits routed to timer channels.
// - Bus modes: address port drives high address.
// - Address port bit n is address n+8 for bits 6:0; bit 7 carries no address.
// - Chip modes: address port resets to inputs, selectable pull-ups.
// - Bus modes: data port is data bus.
// - Chip modes: data port resets to inputs.
// - Serial port has only six pins.
// - Serial direction bits 7:6 read zero.
// - Serial port bits routed to SCI and SPI.
// - Analog port: eight input-only pins.
// - Pull-up enable bit switches port pull-ups.
module pp_ports (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pp_pkg::pp_mode_e op_mode,
  input wire logic [7:0] timer_pin_i,
  output logic [7:0] timer_pin_o,
  output logic [7:0] timer_pin_oe,
  input wire logic [7:0] hiaddr_pin_i,
  output logic [7:0] hiaddr_pin_o,
  output logic [7:0] hiaddr_pin_oe,
  output logic hiaddr_pullup_en,
  input wire logic [7:0] dbus_pin_i,
  output logic [7:0] dbus_pin_o,
  output logic [7:0] dbus_pin_oe,
  input wire logic [5:0] serial_pin_i,
  output logic [5:0] serial_pin_o,
  output logic [5:0] serial_pin_oe,
  input wire logic [7:0] analog_pin_i,
  input wire logic [7:0] timer_alt_en,
  input wire logic [7:0] timer_alt_oe,
  input wire logic [7:3] oc1_mask,
  input wire logic output_compare_one,
  input wire logic output_compare_two,
  input wire logic output_compare_three,
  input wire logic output_compare_four,
  input wire logic output_compare_five,
  output logic input_capture_one,
  output logic input_capture_two,
  output logic input_capture_three,
  output logic input_capture_four,
  output logic pulse_accumulator_input,
  input wire logic sci_alt_en,
  input wire logic first_async_transmit,
  output logic first_async_receive,
  input wire logic [3:0] spi_alt_en,
  input wire logic [3:0] spi_alt_oe,
  input wire logic [3:0] spi_alt_out,
  output logic [3:0] spi_pin_level,
  input wire logic [6:0] ext_addr_hi,
  input wire logic [7:0] ext_data_out,
  input wire logic ext_data_oe,
  output logic [7:0] ext_data_in,
  output logic [7:0] analog_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic bus_mode;
  assign bus_mode = (op_mode == pp_pkg::MODE_EXPANDED) ||
                    (op_mode == pp_pkg::MODE_TEST);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [5:0] idx;
  logic aligned;
  logic hit_timer_data;
  logic hit_timer_dir;
  logic hit_hiaddr_data;
  logic hit_hiaddr_dir;
  logic hit_dbus_data;
  logic hit_dbus_dir;
  logic hit_serial_data;
  logic hit_serial_dir;
  logic hit_analog;
  logic hit_pullup;
  logic hit_any;
  logic access;
  logic wr_stb;

  assign idx = paddr[7:pp_pkg::BYTE_SHIFT];
  assign aligned = (paddr[pp_pkg::BYTE_SHIFT-1:0] == 2'h0);
  assign hit_timer_data = aligned && (idx == pp_pkg::IDX_TIMER_DATA);
  assign hit_timer_dir = aligned && (idx == pp_pkg::IDX_TIMER_DIR);
  assign hit_hiaddr_data = aligned && !bus_mode &&
                           (idx == pp_pkg::IDX_HIADDR_DATA);
  assign hit_hiaddr_dir = aligned && !bus_mode &&
                          (idx == pp_pkg::IDX_HIADDR_DIR);
  assign hit_dbus_data = aligned && !bus_mode &&
                         (idx == pp_pkg::IDX_DBUS_DATA);
  assign hit_dbus_dir = aligned && !bus_mode &&
                        (idx == pp_pkg::IDX_DBUS_DIR);
  assign hit_serial_data = aligned && (idx == pp_pkg::IDX_SERIAL_DATA);
  assign hit_serial_dir = aligned && (idx == pp_pkg::IDX_SERIAL_DIR);
  assign hit_analog = aligned && (idx == pp_pkg::IDX_ANALOG_DATA);
  assign hit_pullup = aligned && (idx == pp_pkg::IDX_PULLUP);
  assign hit_any = hit_timer_data | hit_timer_dir | hit_hiaddr_data |
                   hit_hiaddr_dir | hit_dbus_data | hit_dbus_dir |
                   hit_serial_data | hit_serial_dir | hit_analog |
                   hit_pullup;

  // The answer is prepared in the setup cycle so read data leaves a flop;
  // a clock enable frozen in the access phase stretches it; one frozen in the setup cycle returns the previous read data and error.
  logic cap_valid_reg;
  logic err_reg;

  assign pready = pce && cap_valid_reg;
  assign access = psel && penable && pready;
  assign wr_stb = access && pwrite && hit_any;

  ////////////////////////////////////////////////////////////////////////////
  // Registers with reset

  logic [7:0] timer_dir_reg;
  logic [7:0] hiaddr_dir_reg;
  logic [7:0] dbus_dir_reg;
  logic [pp_pkg::SERIAL_W-1:0] serial_dir_reg;
  logic [pp_pkg::PULLUP_W-1:0] pullup_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_dir_reg <= pp_pkg::DIR_RST;
      hiaddr_dir_reg <= pp_pkg::DIR_RST;
      dbus_dir_reg <= pp_pkg::DIR_RST;
      serial_dir_reg <= pp_pkg::DIR_RST[pp_pkg::SERIAL_W-1:0];
      pullup_reg <= pp_pkg::PULLUP_RST;
    end else if (pce && wr_stb) begin
      if (hit_timer_dir) begin
        timer_dir_reg <= pwdata[7:0];
      end
      if (hit_hiaddr_dir) begin
        hiaddr_dir_reg <= pwdata[7:0];
      end
      if (hit_dbus_dir) begin
        dbus_dir_reg <= pwdata[7:0];
      end
      if (hit_serial_dir) begin
        serial_dir_reg <= pwdata[pp_pkg::SERIAL_W-1:0];
      end
      if (hit_pullup) begin
        pullup_reg <= pwdata[pp_pkg::PULLUP_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers: no reset, plain storage

  logic [7:0] timer_data_reg;
  logic [7:0] hiaddr_data_reg;
  logic [7:0] dbus_data_reg;
  logic [pp_pkg::SERIAL_W-1:0] serial_data_reg;

  always_ff @(posedge pclk) begin
    if (pce && wr_stb) begin
      if (hit_timer_data) begin
        timer_data_reg <= pwdata[7:0];
      end
      if (hit_hiaddr_data) begin
        hiaddr_data_reg <= pwdata[7:0];
      end
      if (hit_dbus_data) begin
        dbus_data_reg <= pwdata[7:0];
      end
      if (hit_serial_data) begin
        serial_data_reg <= pwdata[pp_pkg::SERIAL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [7:0] analog_sync;
  logic [7:0] rd_byte;

  assign rd_byte =
    hit_timer_data ? timer_data_reg :
    hit_timer_dir ? timer_dir_reg :
    hit_hiaddr_data ? hiaddr_data_reg :
    hit_hiaddr_dir ? hiaddr_dir_reg :
    hit_dbus_data ? dbus_data_reg :
    hit_dbus_dir ? dbus_dir_reg :
    hit_serial_data ? {2'h0, serial_data_reg} :
    hit_serial_dir ? {2'h0, serial_dir_reg} :
    hit_analog ? analog_sync :
    hit_pullup ? {4'h0, pullup_reg} :
    8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_valid_reg <= 1'b0;
      prdata <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (pce) begin
      cap_valid_reg <= psel && !(penable && cap_valid_reg);
      if (psel && !penable) begin
        prdata <= {24'h00_0000, rd_byte};
        err_reg <= !hit_any;
      end
    end
  end

  // Unmapped or hidden offsets answer with an error, read data zero
  assign pslverr = pready && psel && penable && err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Timer port

  pp_pkg::pp_alt_s timer_alt;
  logic [7:0] timer_level;
  localparam int TMR0_BIT = pp_pkg::TMR_IC3;

  assign timer_alt.en = timer_alt_en;
  assign timer_alt.oe = timer_alt_oe;
  assign timer_alt.out[TMR0_BIT] = 1'b0;
  assign timer_alt.out[pp_pkg::TMR_IC2] = 1'b0;
  assign timer_alt.out[pp_pkg::TMR_IC1] = 1'b0;
  assign timer_alt.out[pp_pkg::TMR_IC4_OC5] =
    oc1_mask[pp_pkg::TMR_IC4_OC5] ? output_compare_one : output_compare_five;
  assign timer_alt.out[pp_pkg::TMR_OC4] =
    oc1_mask[pp_pkg::TMR_OC4] ? output_compare_one : output_compare_four;
  assign timer_alt.out[pp_pkg::TMR_OC3] =
    oc1_mask[pp_pkg::TMR_OC3] ? output_compare_one : output_compare_three;
  assign timer_alt.out[pp_pkg::TMR_OC2] =
    oc1_mask[pp_pkg::TMR_OC2] ? output_compare_one : output_compare_two;
  assign timer_alt.out[pp_pkg::TMR_PAI] =
    oc1_mask[pp_pkg::TMR_PAI] && output_compare_one;

  pp_pin_slice u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .gp_out(timer_data_reg),
    .gp_dir(timer_dir_reg),
    .alt(timer_alt),
    .pin_i(timer_pin_i),
    .pin_o(timer_pin_o),
    .pin_oe(timer_pin_oe),
    .pin_level(timer_level)
  );

  assign input_capture_three = timer_level[pp_pkg::TMR_IC3];
  assign input_capture_two = timer_level[pp_pkg::TMR_IC2];
  assign input_capture_one = timer_level[pp_pkg::TMR_IC1];
  assign input_capture_four = timer_level[pp_pkg::TMR_IC4_OC5];
  assign pulse_accumulator_input = timer_level[pp_pkg::TMR_PAI];

  ////////////////////////////////////////////////////////////////////////////
  // High-address port

  pp_pkg::pp_alt_s hiaddr_alt;

  assign hiaddr_alt.en = bus_mode ? pp_pkg::HIADDR_MASK : 8'h00;
  assign hiaddr_alt.oe = pp_pkg::HIADDR_MASK;
  assign hiaddr_alt.out = {1'b0, ext_addr_hi};

  pp_pin_slice u_hiaddr (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .gp_out(hiaddr_data_reg),
    .gp_dir(hiaddr_dir_reg),
    .alt(hiaddr_alt),
    .pin_i(hiaddr_pin_i),
    .pin_o(hiaddr_pin_o),
    .pin_oe(hiaddr_pin_oe),
    .pin_level()
  );

  assign hiaddr_pullup_en = pullup_reg[pp_pkg::PULLUP_HIADDR_BIT] &&
                            !bus_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Data-bus port

  pp_pkg::pp_alt_s dbus_alt;

  // bit n is data line n
  assign dbus_alt.en = bus_mode ? 8'hFF : 8'h00;
  assign dbus_alt.oe = ext_data_oe ? 8'hFF : 8'h00;
  assign dbus_alt.out = ext_data_out;

  pp_pin_slice u_dbus (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .gp_out(dbus_data_reg),
    .gp_dir(dbus_dir_reg),
    .alt(dbus_alt),
    .pin_i(dbus_pin_i),
    .pin_o(dbus_pin_o),
    .pin_oe(dbus_pin_oe),
    .pin_level(ext_data_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial port

  pp_pkg::pp_alt_s serial_alt;
  logic [7:0] serial_o_w;
  logic [7:0] serial_oe_w;
  logic [7:0] serial_level;

  // SCI on 0-1, SPI on 2-5
  assign serial_alt.en = {2'h0, spi_alt_en, sci_alt_en, sci_alt_en};
  assign serial_alt.oe = {2'h0, spi_alt_oe, sci_alt_en, 1'b0};
  assign serial_alt.out = {2'h0, spi_alt_out, first_async_transmit, 1'b0};

  pp_pin_slice u_serial (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .gp_out({2'h0, serial_data_reg}),
    .gp_dir({2'h0, serial_dir_reg}),
    .alt(serial_alt),
    .pin_i({2'h0, serial_pin_i}),
    .pin_o(serial_o_w),
    .pin_oe(serial_oe_w),
    .pin_level(serial_level)
  );

  assign serial_pin_o = serial_o_w[pp_pkg::SERIAL_W-1:0];
  assign serial_pin_oe = serial_oe_w[pp_pkg::SERIAL_W-1:0];
  assign first_async_receive = serial_level[pp_pkg::SER_RXD];
  assign spi_pin_level = serial_level[pp_pkg::SER_SS:pp_pkg::SER_MISO];

  ////////////////////////////////////////////////////////////////////////////
  // Analog port: input only

  logic [7:0] analog_meta_reg;
  logic [7:0] analog_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_meta_reg <= 8'h00;
      analog_sync_reg <= 8'h00;
    end else if (pce) begin
      analog_meta_reg <= analog_pin_i;
      analog_sync_reg <= analog_meta_reg;
    end
  end

  assign analog_sync = analog_sync_reg;
  assign analog_level = analog_sync_reg;

endmodule

// >>> pp_pkg.sv
package pp_pkg;

  // Register indices; the APB byte address is the index shifted left by two
  localparam int IDX_W = 6;
  localparam int BYTE_SHIFT = 2;
  localparam logic [5:0] IDX_TIMER_DATA = 6'h00;
  localparam logic [5:0] IDX_TIMER_DIR = 6'h01;
  localparam logic [5:0] IDX_HIADDR_DIR = 6'h02;
  localparam logic [5:0] IDX_HIADDR_DATA = 6'h04;
  localparam logic [5:0] IDX_DBUS_DATA = 6'h06;
  localparam logic [5:0] IDX_DBUS_DIR = 6'h07;
  localparam logic [5:0] IDX_SERIAL_DATA = 6'h08;
  localparam logic [5:0] IDX_SERIAL_DIR = 6'h09;
  localparam logic [5:0] IDX_ANALOG_DATA = 6'h0A;
  localparam logic [5:0] IDX_PULLUP = 6'h2C;

  // Reset values and field layouts
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [3:0] PULLUP_RST = 4'hF;
  localparam logic [7:0] SERIAL_MASK = 8'h3F;
  localparam logic [7:0] HIADDR_MASK = 8'h7F;
  localparam int PULLUP_HIADDR_BIT = 0;
  localparam int SERIAL_W = 6;
  localparam int PULLUP_W = 4;

  // Timer port bit positions
  localparam int TMR_IC3 = 0;
  localparam int TMR_IC2 = 1;
  localparam int TMR_IC1 = 2;
  localparam int TMR_IC4_OC5 = 3;
  localparam int TMR_OC4 = 4;
  localparam int TMR_OC3 = 5;
  localparam int TMR_OC2 = 6;
  localparam int TMR_PAI = 7;

  // Serial port bit positions
  localparam int SER_RXD = 0;
  localparam int SER_TXD = 1;
  localparam int SER_MISO = 2;
  localparam int SER_MOSI = 3;
  localparam int SER_SCK = 4;
  localparam int SER_SS = 5;

  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_EXPANDED,
    MODE_BOOTSTRAP,
    MODE_TEST
  } pp_mode_e;

  // Peripheral claim on a port: ownership, drive enable and drive value
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] oe;
    logic [7:0] out;
  } pp_alt_s;

endpackage

// >>> pp_pin_slice.sv
`timescale 1ns/100ps
module pp_pin_slice (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [7:0] gp_out,
  input wire logic [7:0] gp_dir,
  input wire pp_pkg::pp_alt_s alt,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_level
);

  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  logic [7:0] out_next;
  logic [7:0] oe_next;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // A peripheral that owns the pin overrides the data register
      assign out_next[i] = alt.en[i] ? alt.out[i] : gp_out[i];
      assign oe_next[i] = alt.en[i] ? alt.oe[i] : gp_dir[i];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
          pin_o[i] <= 1'b0;
          pin_oe[i] <= 1'b0;
        end else if (pce) begin
          meta_reg[i] <= pin_i[i];
          sync_reg[i] <= meta_reg[i];
          pin_o[i] <= out_next[i];
          pin_oe[i] <= oe_next[i];
        end
      end
    end
  endgenerate

  assign pin_level = sync_reg;

endmodule

// >>> pp_ports_assertions.sv
`timescale 1ns/100ps
module pp_ports_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pp_pkg::pp_mode_e op_mode,
  input wire logic [7:0] timer_pin_i,
  input wire logic [7:0] timer_pin_oe,
  input wire logic [7:0] hiaddr_pin_o,
  input wire logic [7:0] hiaddr_pin_oe,
  input wire logic hiaddr_pullup_en,
  input wire logic [7:0] dbus_pin_oe,
  input wire logic [5:0] serial_pin_i,
  input wire logic [5:0] serial_pin_oe,
  input wire logic [7:0] analog_pin_i,
  input wire logic input_capture_one,
  input wire logic input_capture_two,
  input wire logic input_capture_three,
  input wire logic input_capture_four,
  input wire logic pulse_accumulator_input,
  input wire logic first_async_receive,
  input wire logic [3:0] spi_pin_level,
  input wire logic [6:0] ext_addr_hi,
  input wire logic ext_data_oe,
  input wire logic [7:0] analog_level
);
  logic bus_m;
  logic acc;
  logic [1:0] run_q;

  assign bus_m = op_mode inside {pp_pkg::MODE_EXPANDED, pp_pkg::MODE_TEST};
  assign acc = psel && penable && pready;

  // Clock enable at each of the last two edges; synchronisers need two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 2'h0;
    end else begin
      run_q <= {run_q[0], pce};
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  rdy_after_setup_a:
    assert property (psel && !penable && pce ##1 pce |-> pready)
    else $error("no ready after setup");
  err_in_access_a:
    assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  dir_reset_a:
    assert property ($rose(presetn) |-> timer_pin_oe == 8'h00
      && serial_pin_oe == 6'h00)
    else $error("pins driven after reset");
  addr_bus_a:
    assert property (bus_m && $past(bus_m) && run_q[0] |->
      hiaddr_pin_oe[6:0] == 7'h7F && hiaddr_pin_o[6:0] == $past(ext_addr_hi))
    else $error("high address wrong");
  dbus_drive_a:
    assert property (bus_m && $past(bus_m) && run_q[0] |->
      dbus_pin_oe == {8{$past(ext_data_oe)}})
    else $error("data bus drive wrong");
  timer_sync_a:
    assert property (run_q == 2'h3 |-> {pulse_accumulator_input,
      input_capture_four, input_capture_one, input_capture_two,
      input_capture_three} == $past({timer_pin_i[7], timer_pin_i[3:0]}, 2))
    else $error("timer input routing wrong");
  serial_sync_a:
    assert property (run_q == 2'h3 |-> {first_async_receive, spi_pin_level}
      == $past({serial_pin_i[0], serial_pin_i[5:2]}, 2))
    else $error("serial input routing wrong");
  analog_sync_a:
    assert property (run_q == 2'h3 |-> analog_level == $past(analog_pin_i, 2))
    else $error("analog level wrong");
  serial_zero_a:
    assert property (acc && !pwrite && paddr inside {8'h20, 8'h24} |->
      prdata[31:6] == 26'h0)
    else $error("serial upper bits set");
  pullup_mode_a:
    assert property (hiaddr_pullup_en |-> !bus_m)
    else $error("pull-up on in bus mode");
  hidden_err_a:
    assert property (acc && bus_m && paddr inside {8'h08, 8'h10, 8'h18,
      8'h1C} |-> pslverr)
    else $error("hidden register answered");
endmodule

bind pp_ports pp_ports_chk i_pp_ports_chk (.*);

// >>> pp_pad_model.sv
`timescale 1ns/100ps
module pp_pad_model #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic [W-1:0] pin_o,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  input wire logic pull_up,
  output logic [W-1:0] pin_i
);
  logic [W-1:0] last_reg;

  // A floating pad toggles so a stale value is never read as valid
  always @(posedge pclk) begin
    last_reg <= (last_reg === 'x) ? '0 : pin_i;
  end
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_up ? '1 : ~last_reg));
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  logic pclk, presetn, pce, psel, penable, pwrite, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, hiaddr_pullup_en, bus;
  pp_pkg::pp_mode_e op_mode;
  logic [7:0] timer_pin_i, timer_pin_o, timer_pin_oe;
  logic [7:0] timer_alt_en, timer_alt_oe, analog_pin_i, analog_level;
  logic [7:0] hiaddr_pin_i, hiaddr_pin_o, hiaddr_pin_oe;
  logic [7:0] dbus_pin_i, dbus_pin_o, dbus_pin_oe;
  logic [5:0] serial_pin_i, serial_pin_o, serial_pin_oe;
  logic [7:3] oc1_mask;
  logic output_compare_one, output_compare_two, output_compare_three;
  logic output_compare_four, output_compare_five, pulse_accumulator_input;
  logic input_capture_one, input_capture_two, input_capture_three;
  logic input_capture_four, sci_alt_en, first_async_transmit;
  logic first_async_receive, ext_data_oe;
  logic [3:0] spi_alt_en, spi_alt_oe, spi_alt_out, spi_pin_level;
  logic [6:0] ext_addr_hi;
  logic [7:0] ext_data_out, ext_data_in, t_ev, t_ee, c_ev, c_ee;
  logic [5:0] s_ev, s_ee;
  logic [7:0] b_ev, b_ee;
  int n_fail, samples_checked, cyc;
  localparam logic [7:0] DA [4] = '{8'h00, 8'h10, 8'h18, 8'h20};
  localparam logic [7:0] DR [4] = '{8'h04, 8'h08, 8'h1C, 8'h24};

  pp_ports i_pp_ports (.*);
  pp_pad_model i_pp_pad_model_t (.pclk(pclk), .pin_o(timer_pin_o),
    .pin_oe(timer_pin_oe), .ext_val(t_ev), .ext_en(t_ee), .pull_up(1'b0),
    .pin_i(timer_pin_i));
  pp_pad_model i_pp_pad_model_b (.pclk(pclk), .pin_o(hiaddr_pin_o),
    .pin_oe(hiaddr_pin_oe), .ext_val(b_ev), .ext_en(b_ee),
    .pull_up(hiaddr_pullup_en), .pin_i(hiaddr_pin_i));
  pp_pad_model i_pp_pad_model_c (.pclk(pclk), .pin_o(dbus_pin_o),
    .pin_oe(dbus_pin_oe), .ext_val(c_ev), .ext_en(c_ee), .pull_up(1'b0),
    .pin_i(dbus_pin_i));
  pp_pad_model #(.W(6)) i_pp_pad_model_d (.pclk(pclk), .pin_o(serial_pin_o),
    .pin_oe(serial_pin_oe), .ext_val(s_ev), .ext_en(s_ee), .pull_up(1'b0),
    .pin_i(serial_pin_i));

  always #5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Request stands until pready is seen at a rising edge; data taken there
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    pce = 1'b1;
    first_async_transmit = 1'b1;
    op_mode = pp_pkg::MODE_SINGLE_CHIP;
    {presetn, psel, penable, pwrite, paddr, pwdata, sci_alt_en} = '0;
    {timer_alt_en, timer_alt_oe, oc1_mask, analog_pin_i, ext_data_oe} = '0;
    {output_compare_one, output_compare_two, output_compare_three} = '0;
    {output_compare_four, output_compare_five, spi_alt_en} = '0;
    {spi_alt_oe, spi_alt_out, ext_addr_hi, ext_data_out} = '0;
    {t_ev, t_ee, c_ev, c_ee, s_ev, s_ee, n_fail, samples_checked, cyc} = '0;
    {b_ev, b_ee} = '0;
    tick(4);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(DR[i], 1'b0, 8'h00);
      check(rd, 32'h0);
    end
    xfer(8'hB0, 1'b0, 8'h00);
    check({rd[3:0], hiaddr_pullup_en}, 5'h1F);
    check({timer_pin_oe, hiaddr_pin_oe, dbus_pin_oe, serial_pin_oe}, 0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      xfer(DA[i], 1'b1, 8'hA5);
      xfer(DR[i], 1'b1, 8'hFC);
      xfer(DA[i], 1'b0, 8'h00);
      check(rd, i == 3 ? 32'h25 : 32'hA5);
      xfer(DR[i], 1'b0, 8'h00);
      check(rd, i == 3 ? 32'h3C : 32'hFC);
    end
    check({timer_pin_oe, hiaddr_pin_oe, dbus_pin_oe, 2'h0, serial_pin_oe},
      32'hFCFCFC3C);
    check({timer_pin_o & timer_pin_oe, hiaddr_pin_o & hiaddr_pin_oe,
      dbus_pin_o & dbus_pin_oe, 2'h0, serial_pin_o & serial_pin_oe},
      32'hA4A4A424);
    t_ee <= 8'h03;
    t_ev <= 8'h01;
    tick(3);
    check({input_capture_two, input_capture_three}, 2'h1);
    // Clock enable low must freeze the synchronisers
    pce <= 1'b0;
    t_ev <= 8'h00;
    tick(4);
    check(input_capture_three, 1'b1);
    pce <= 1'b1;
    tick(3);
    check(input_capture_three, 1'b0);
    $display("general purpose test done");
    timer_alt_en <= 8'h10;
    timer_alt_oe <= 8'h10;
    output_compare_four <= 1'b1;
    xfer(8'h00, 1'b1, 8'h00);
    tick(2);
    check({timer_pin_oe[4], timer_pin_o[4]}, 2'h3);
    xfer(8'h00, 1'b0, 8'h00);
    check(rd, 32'h0);
    oc1_mask[4] <= 1'b1;
    tick(2);
    check(timer_pin_o[4], 1'b0);
    sci_alt_en <= 1'b1;
    first_async_transmit <= 1'b0;
    spi_alt_en <= 4'hF;
    s_ee <= 6'h3D;
    s_ev <= 6'h2D;
    analog_pin_i <= 8'h5A;
    tick(4);
    check({serial_pin_oe[1], serial_pin_o[1]}, 2'h2);
    check({first_async_receive, spi_pin_level}, 5'h1B);
    check(analog_level, 8'h5A);
    xfer(8'h0C, 1'b0, 8'h00);
    check(er, 1'b1);
    check(rd, 32'h0);
    $display("alternate function test done");
    ext_addr_hi <= 7'h55;
    ext_data_out <= 8'hC3;
    ext_data_oe <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      op_mode <= pp_pkg::pp_mode_e'(m);
      bus = m[0];
      tick(3);
      check({hiaddr_pin_oe[6:0], hiaddr_pin_o[6:0] & hiaddr_pin_oe[6:0]},
        bus ? 14'h3FD5 : 14'h3E24);
      check({dbus_pin_oe, dbus_pin_o & dbus_pin_oe}, bus ? 16'hFFC3
        : (m == 0 ? 16'hFCA4 : 16'hFC00));
      check(hiaddr_pullup_en, !bus);
      xfer(8'h18, 1'b1, 8'(m));
      check(er, bus);
      xfer(8'h08, 1'b0, 8'h00);
      check(er, bus);
    end
    ext_data_oe <= 1'b0;
    c_ev <= 8'h96;
    c_ee <= 8'hFF;
    tick(4);
    check(ext_data_in, 8'h96);
    c_ee <= 8'h00;
    op_mode <= pp_pkg::MODE_SINGLE_CHIP;
    xfer(8'h18, 1'b0, 8'h00);
    check(rd, 32'h2);
    $display("mode test done");
    summarize();
  end
endmodule
